// ==== hw/bml_loader.sv ====
// Boot mode loader: mode sampling, decode and loading sequencer
`include "bml_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module bml_loader
    import bml_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic sys_clk, // 250 MHz system clock
    input wire logic rst_n, // Power-on reset, async, low
    input wire logic sw_reset, // Software reset pulse, resamples mode
    input wire logic [3:0] boot_select_pins, // Mode pins, asynchronous
    input wire logic otp_async_ready_input_enable, // OTP enables async ready input
    input wire logic otp_twowire_one_byte, // OTP: one address byte memory
    input wire logic otp_page_override, // OTP start page is valid
    input wire logic [7:0] otp_start_page, // OTP programmed start page
    input wire logic load_step, // One unit fetched by the datapath
    input wire logic spi_detected, // SPI memory answered validly
    input wire logic loader_busy, // Datapath cannot take a byte
    input wire logic uart_zero_receive, // UART port zero receive pin
    input wire logic uart_one_receive, // UART port one receive pin
    output logic [3:0] boot_mode, // Held decoded mode
    output bml_state_type loader_state, // Sequencer state
    output bml_cfg_type boot_cfg, // Setup for the selected procedure
    output logic host_wait, // High holds off the boot host
    output logic dma_request_one_n, // Low pulse requests a FIFO word
    output logic spi_memory_select_gpio_n, // SPI memory select, low
    output logic [2:0] spi_addr_bytes, // Zero address bytes sent so far
    output logic [7:0] otp_page, // Current OTP page
    output logic uart_zero_transmit, // UART port zero transmit pin
    output logic uart_one_transmit, // UART port one transmit pin
    output logic [DIV_W-1:0] uart_divisor // Measured bit divisor
);
    initial begin
        if (DIV_W < 8 || DIV_W > 16) begin
            $error("DIV_W must lie between 8 and 16");
        end
    end

    bml_state_type state_ff, nxt_state;
    logic [3:0] pin_meta_ff, pin_sync_ff, mode_ff;
    logic [1:0] wait_ff;
    bml_cfg_type cfg_ff, nxt_cfg;
    logic [2:0] rx0_ff, rx1_ff;
    logic host_wait_ff, dreq_n_ff, spi_sel_n_ff, tx0_ff, tx1_ff;
    logic [2:0] spi_bytes_ff;
    logic [7:0] otp_page_ff;
    logic [6:0] ab_sub_ff;
    logic [DIV_W-1:0] div_ff;
    logic ab_run_ff;
    logic [9:0] tx_shift_ff;
    logic [3:0] tx_bits_ff;
    logic [1:0] tx_byte_ff;
    logic [DIV_W+3:0] bit_cnt_ff;

    // Mode decode, held in mode_ff from sampling onward
    wire is_idle = (mode_ff == `BML_MODE_IDLE) || (mode_ff == `BML_MODE_RSVD);
    wire is_uart = (mode_ff == `BML_MODE_UART0) || (mode_ff == `BML_MODE_UART1);
    wire is_host = is_uart || (mode_ff == `BML_MODE_SPIHOST) || (mode_ff == `BML_MODE_TWHOST);
    wire use_port_one = (mode_ff == `BML_MODE_UART1);
    // Bit 1 of the receive pipe is the second synchroniser stage
    wire rx_now = use_port_one ? rx1_ff[1] : rx0_ff[1];
    wire rx_old = use_port_one ? rx1_ff[2] : rx0_ff[2];
    wire rx_fall = rx_old && !rx_now;
    wire rx_rise = !rx_old && rx_now;
    wire [DIV_W-1:0] div_eff = (div_ff == '0) ? DIV_W'(1) : div_ff;
    wire [DIV_W+3:0] bit_len = {div_eff, 4'h0};
    wire bit_tick = (bit_cnt_ff == bit_len - (DIV_W+4)'(1));
    wire [7:0] ack_byte = (tx_byte_ff == 2'h0) ? `BML_ACK_FIRST :
                          (tx_byte_ff == 2'h1) ? div_eff[7:0] :
                          (tx_byte_ff == 2'h2) ? 8'(div_eff >> 8) : `BML_ACK_LAST;
    wire ack_done = bit_tick && (tx_bits_ff == 4'h9) && (tx_byte_ff == 2'h3);
    wire otp_end = (otp_page_ff == `BML_OTP_LAST_PAGE);
    wire [7:0] otp_first = otp_page_override ? otp_start_page : `BML_OTP_FIRST_PAGE;
    // Byte loaded at the end of each acknowledge frame
    wire [1:0] next_idx = tx_byte_ff + 2'h1;
    wire [7:0] ack_next = (next_idx == 2'h1) ? div_eff[7:0] :
                          (next_idx == 2'h2) ? 8'(div_eff >> 8) : `BML_ACK_LAST;

    // Per-mode setup; every mode begins at its slowest settings
    always_comb begin
        nxt_cfg = '0;
        nxt_cfg.async_hold = `BML_ASYNC_HOLD;
        nxt_cfg.async_access = `BML_ASYNC_ACCESS;
        nxt_cfg.async_setup = `BML_ASYNC_SETUP;
        nxt_cfg.spi_baud = `BML_SPI_BAUD;
        nxt_cfg.tw_twowire_prescaler = `BML_TW_TWOWIRE_PRESCALER;
        nxt_cfg.tw_clkdiv = `BML_TW_CLKDIV;
        nxt_cfg.tw_addr_bytes = otp_twowire_one_byte ? 3'h1 : 3'h2;
        nxt_cfg.nand_ctl = `BML_NAND_CTL;
        nxt_cfg.nand_addr_cycles = `BML_NAND_ADDR_CYCLES;
        nxt_cfg.start_addr = `BML_ADDR_ZERO;
        case (pin_sync_ff)
            `BML_MODE_PFLASH: begin
                nxt_cfg.start_addr = `BML_ADDR_PFLASH;
                nxt_cfg.async_pins_en = 1'b1;
                nxt_cfg.async_ready_input_en = otp_async_ready_input_enable;
            end
            `BML_MODE_AFIFO: begin
                nxt_cfg.start_addr = `BML_ADDR_AFIFO;
                nxt_cfg.async_pins_en = 1'b1;
            end
            `BML_MODE_TWMEM: nxt_cfg.tw_dev_id = `BML_TW_MEM_ID;
            `BML_MODE_TWHOST: nxt_cfg.tw_dev_id = `BML_TW_HOST_ID;
            `BML_MODE_SDRAM: nxt_cfg.start_addr = `BML_ADDR_SDRAM;
            `BML_MODE_NANDH: nxt_cfg.nand_data_on_port_h = 1'b1;
            default: nxt_cfg.nand_data_on_port_h = 1'b0;
        endcase
    end

    // Sequencer; a software reset always returns to sampling
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SAMPLE: if (wait_ff == `BML_SYNC_WAIT) nxt_state = ST_DECODE;
            ST_DECODE: nxt_state = is_idle ? ST_IDLE : (is_uart ? ST_AUTOBAUD : ST_LOAD);
            ST_IDLE: nxt_state = ST_IDLE;
            ST_AUTOBAUD: if (ab_run_ff && rx_rise) nxt_state = ST_ACK;
            ST_ACK: if (ack_done) nxt_state = ST_LOAD;
            ST_LOAD: nxt_state = ST_LOAD;
            default: nxt_state = ST_SAMPLE;
        endcase
        if (sw_reset) nxt_state = ST_SAMPLE;
    end

    // Pin synchronisers; pins are only read after two stages
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
            rx0_ff <= 3'h7;
            rx1_ff <= 3'h7;
        end else begin
            pin_meta_ff <= boot_select_pins;
            pin_sync_ff <= pin_meta_ff;
            rx0_ff <= {rx0_ff[1:0], uart_zero_receive};
            rx1_ff <= {rx1_ff[1:0], uart_one_receive};
        end
    end

    // State, mode latch and setup; the mode moves only on a reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_SAMPLE;
            wait_ff <= 2'h0;
            mode_ff <= 4'h0;
            cfg_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= (state_ff == ST_SAMPLE && !sw_reset) ? wait_ff + 2'h1 : 2'h0;
            if (state_ff == ST_SAMPLE && wait_ff == `BML_SYNC_WAIT) begin
                mode_ff <= pin_sync_ff;
                cfg_ff <= nxt_cfg;
            end
        end
    end

    // Host wait: high through preboot, autobaud and acknowledge, then follows the datapath
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_wait_ff <= 1'b1;
        end else begin
            host_wait_ff <= (nxt_state == ST_LOAD) ? loader_busy : 1'b1;
        end
    end

    // FIFO word request and SPI memory probe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dreq_n_ff <= 1'b1;
            spi_sel_n_ff <= 1'b1;
            spi_bytes_ff <= 3'h0;
        end else begin
            dreq_n_ff <= !(state_ff == ST_LOAD && mode_ff == `BML_MODE_AFIFO && load_step);
            spi_sel_n_ff <= !(state_ff == ST_LOAD && mode_ff == `BML_MODE_SPIMEM);
            if (state_ff != ST_LOAD) begin
                spi_bytes_ff <= 3'h0;
            end else if (mode_ff == `BML_MODE_SPIMEM && load_step && !spi_detected &&
                         spi_bytes_ff != `BML_SPI_MAX_ADDR_BYTES) begin
                spi_bytes_ff <= spi_bytes_ff + 3'h1;
            end
        end
    end

    // OTP page walk stops at the last public page
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_page_ff <= `BML_OTP_FIRST_PAGE;
        end else if (state_ff == ST_DECODE) begin
            otp_page_ff <= otp_first;
        end else if (state_ff == ST_LOAD && mode_ff == `BML_MODE_OTP && load_step && !otp_end) begin
            otp_page_ff <= otp_page_ff + 8'h01;
        end
    end

    // Autobaud: 0x40 stays low for seven bits, so count that low time in 112ths
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ab_run_ff <= 1'b0;
            ab_sub_ff <= 7'h00;
            div_ff <= '0;
        end else if (state_ff == ST_AUTOBAUD) begin
            if (!ab_run_ff && rx_fall) begin
                // The falling edge cycle is already low time, so it counts
                ab_run_ff <= 1'b1;
                ab_sub_ff <= 7'h01;
                div_ff <= '0;
            end else if (ab_run_ff && !rx_now) begin
                ab_sub_ff <= (ab_sub_ff == `BML_AUTOBAUD_LOW_BITS - 7'h01) ? 7'h00 : ab_sub_ff + 7'h01;
                if (ab_sub_ff == `BML_AUTOBAUD_LOW_BITS - 7'h01) div_ff <= div_ff + DIV_W'(1);
            end
        end else begin
            ab_run_ff <= 1'b0;
        end
    end

    // Acknowledge sender, sixteen clocks per divisor step, LSB first
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= '0;
            tx_bits_ff <= 4'h0;
            tx_byte_ff <= 2'h0;
            tx_shift_ff <= 10'h3FF;
        end else if (state_ff != ST_ACK) begin
            bit_cnt_ff <= '0;
            tx_bits_ff <= 4'h0;
            tx_byte_ff <= 2'h0;
            tx_shift_ff <= {1'b1, `BML_ACK_FIRST, 1'b0};
        end else if (bit_tick) begin
            bit_cnt_ff <= '0;
            if (tx_bits_ff == 4'h9) begin
                tx_bits_ff <= 4'h0;
                tx_byte_ff <= tx_byte_ff + 2'h1;
                tx_shift_ff <= {1'b1, ack_next, 1'b0};
            end else begin
                tx_bits_ff <= tx_bits_ff + 4'h1;
                tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
            end
        end else begin
            bit_cnt_ff <= bit_cnt_ff + (DIV_W+4)'(1);
        end
    end
    // Transmit pins idle high; only the selected port talks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx0_ff <= 1'b1;
            tx1_ff <= 1'b1;
        end else begin
            tx0_ff <= (state_ff == ST_ACK && !use_port_one) ? tx_shift_ff[0] : 1'b1;
            tx1_ff <= (state_ff == ST_ACK && use_port_one) ? tx_shift_ff[0] : 1'b1;
        end
    end

    assign boot_mode = mode_ff;
    assign loader_state = state_ff;
    assign boot_cfg = cfg_ff;
    assign host_wait = host_wait_ff;
    assign dma_request_one_n = dreq_n_ff;
    assign spi_memory_select_gpio_n = spi_sel_n_ff;
    assign spi_addr_bytes = spi_bytes_ff;
    assign otp_page = otp_page_ff;
    assign uart_zero_transmit = tx0_ff;
    assign uart_one_transmit = tx1_ff;
    assign uart_divisor = div_eff;

    // Checks
    property p_idle_stays;
        @(posedge sys_clk) disable iff (!rst_n || sw_reset)
        state_ff == ST_IDLE |=> state_ff == ST_IDLE && host_wait_ff;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("idle left");
    property p_mode_held;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff != ST_SAMPLE) && !sw_reset |=> $stable(mode_ff);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode moved");
    property p_flash_cfg;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_DECODE && mode_ff == `BML_MODE_PFLASH |-> cfg_ff.start_addr ==
            `BML_ADDR_PFLASH && cfg_ff.async_access == 4'hF && cfg_ff.async_pins_en;
    endproperty
    a_flash_cfg: assert property (p_flash_cfg) else $error("flash setup wrong");
    property p_async_ready_input;
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_ff.async_ready_input_en |-> mode_ff == `BML_MODE_PFLASH;
    endproperty
    a_async_ready_input: assert property (p_async_ready_input) else $error("ready enabled");
    property p_dreq;
        @(posedge sys_clk) disable iff (!rst_n)
        !dreq_n_ff |-> mode_ff == `BML_MODE_AFIFO && $past(load_step) &&
            $past(state_ff) == ST_LOAD;
    endproperty
    a_dreq: assert property (p_dreq) else $error("stray request");
    property p_wait_load;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff != ST_LOAD && !(nxt_state == ST_LOAD) |=> host_wait_ff;
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("host released early");
    property p_twowire;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_LOAD && mode_ff == `BML_MODE_TWMEM |-> cfg_ff.tw_dev_id == 8'hA0 &&
            cfg_ff.tw_clkdiv == 16'h0811 && cfg_ff.tw_twowire_prescaler == 8'h0A;
    endproperty
    a_twowire: assert property (p_twowire) else $error("two-wire setup wrong");
    property p_otp_bound;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_LOAD && otp_end |=> otp_page_ff == 8'hDF;
    endproperty
    a_otp_bound: assert property (p_otp_bound) else $error("otp past end");
    property p_ack_start;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(state_ff == ST_ACK) |=> (use_port_one ? !tx1_ff : !tx0_ff);
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("no start bit");
    c_uart: cover property (@(posedge sys_clk) state_ff == ST_ACK ##1 state_ff == ST_LOAD);
    c_idle: cover property (@(posedge sys_clk) state_ff == ST_IDLE);
    c_fifo: cover property (@(posedge sys_clk) !dreq_n_ff);
endmodule : bml_loader
`default_nettype wire

// ==== hw/bml_consts.svh ====
// Constants of the boot mode loader: mode codes, addresses and defaults
`ifndef BML_CONSTS_SVH
`define BML_CONSTS_SVH
`define BML_MODE_IDLE 4'h0
`define BML_MODE_PFLASH 4'h1
`define BML_MODE_AFIFO 4'h2
`define BML_MODE_SPIMEM 4'h3
`define BML_MODE_SPIHOST 4'h4
`define BML_MODE_TWMEM 4'h5
`define BML_MODE_TWHOST 4'h6
`define BML_MODE_UART0 4'h7
`define BML_MODE_UART1 4'h8
`define BML_MODE_RSVD 4'h9
`define BML_MODE_SDRAM 4'hA
`define BML_MODE_OTP 4'hB
`define BML_MODE_NANDF 4'hC
`define BML_MODE_NANDH 4'hD
`define BML_ADDR_PFLASH 32'h2000_0000
`define BML_ADDR_AFIFO 32'h2030_0000
`define BML_ADDR_SDRAM 32'h0000_0010
`define BML_ADDR_ZERO 32'h0000_0000
`define BML_ASYNC_HOLD 4'h3
`define BML_ASYNC_ACCESS 4'hF
`define BML_ASYNC_SETUP 4'h4
`define BML_SPI_BAUD 16'h0085
`define BML_SPI_ADDR_BYTE 8'h00
`define BML_SPI_MAX_ADDR_BYTES 3'h4
`define BML_TW_TWOWIRE_PRESCALER 8'h0A
`define BML_TW_CLKDIV 16'h0811
`define BML_TW_MEM_ID 8'hA0
`define BML_TW_HOST_ID 8'h5F
`define BML_NAND_CTL 16'h0033
`define BML_NAND_ADDR_CYCLES 3'h4
`define BML_NAND_PAGE_BYTES 10'h200
`define BML_NAND_PAGES_PER_BLK 6'h20
`define BML_NAND_SPARE_BYTES 5'h10
`define BML_OTP_FIRST_PAGE 8'h40
`define BML_OTP_LAST_PAGE 8'hDF
`define BML_AUTOBAUD_CHAR 8'h40
`define BML_ACK_FIRST 8'hBF
`define BML_ACK_LAST 8'h00
`define BML_AUTOBAUD_LOW_BITS 7'h70
`define BML_SYNC_WAIT 2'h3
`endif

// ==== hw/bml_pkg.sv ====
// Types shared by the boot mode loader
package bml_pkg;
    typedef enum logic [5:0] {
        ST_SAMPLE = 6'h01,
        ST_DECODE = 6'h02,
        ST_IDLE = 6'h04,
        ST_AUTOBAUD = 6'h08,
        ST_ACK = 6'h10,
        ST_LOAD = 6'h20
    } bml_state_type;

    typedef struct packed {
        logic [31:0] start_addr;
        logic [3:0] async_hold;
        logic [3:0] async_access;
        logic [3:0] async_setup;
        logic async_pins_en;
        logic async_ready_input_en;
        logic [15:0] spi_baud;
        logic [7:0] tw_twowire_prescaler;
        logic [15:0] tw_clkdiv;
        logic [7:0] tw_dev_id;
        logic [2:0] tw_addr_bytes;
        logic [15:0] nand_ctl;
        logic nand_data_on_port_h;
        logic [2:0] nand_addr_cycles;
    } bml_cfg_type;
endpackage : bml_pkg

// ==== verif/bml_uart_host.sv ====
// Boot host model: sends UART characters and decodes the device acknowledge
`timescale 1ns/1ns
`default_nettype none
module bml_uart_host #(
    parameter int BIT_CYC = 64
) (
    input wire logic sys_clk, // System clock
    input wire logic host_wait, // High holds the host off
    input wire logic host_rx, // Device transmit line
    output logic host_tx, // Host transmit line, idles high
    output logic [31:0] got_word, // Last four bytes, newest on top
    output logic [7:0] got_count // Frames received
);
    logic [7:0] rx_sh;

    initial begin
        host_tx = 1'b1;
        got_word = 32'h0;
        got_count = 8'h00;
    end

    // One 8N1 frame, LSB first; stream bytes wait for host_wait low first
    task automatic send_byte(input logic [7:0] b, input logic gated);
        logic [9:0] frame;
        int guard;
        frame = {1'b1, b, 1'b0};
        guard = 0;
        while (gated && host_wait !== 1'b0 && guard < 20000) begin
            @(posedge sys_clk);
            guard++;
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            host_tx <= frame[i];
            repeat (BIT_CYC - 1) @(posedge sys_clk);
        end
    endtask : send_byte

    // Mid-bit sampling; a frame without its stop bit is dropped
    always begin
        @(negedge host_rx);
        repeat (BIT_CYC / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk);
            rx_sh[i] = host_rx;
        end
        repeat (BIT_CYC) @(posedge sys_clk);
        if (host_rx === 1'b1) begin
            got_word = {rx_sh, got_word[31:8]};
            got_count = got_count + 8'h01;
        end
    end
endmodule : bml_uart_host
`default_nettype wire

// ==== verif/tb_bml_loader.sv ====
// Testbench of the boot mode loader: decode table, sequencer and UART handshake
`timescale 1ns/1ns
`default_nettype none
module tb_bml_loader
    import bml_pkg::*;
    ;
    typedef struct packed {
        logic [3:0] mode;
        bml_state_type st;
        logic chk;
        logic [31:0] addr;
    } bml_row_type;

    logic sys_clk = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, load_step = 1'b0;
    logic otp_async_ready_input_enable = 1'b0, otp_twowire_one_byte = 1'b0, otp_page_override = 1'b0;
    logic spi_detected = 1'b0, loader_busy = 1'b0, port_one = 1'b0;
    logic [3:0] boot_select_pins = 4'h0;
    logic [7:0] otp_start_page = 8'h00;
    logic [3:0] boot_mode;
    bml_state_type loader_state;
    bml_cfg_type boot_cfg;
    logic host_wait, dma_request_one_n, spi_memory_select_gpio_n, host_tx, host_rx;
    logic uart_zero_transmit, uart_one_transmit, uart_zero_receive, uart_one_receive;
    logic [2:0] spi_addr_bytes;
    logic [7:0] otp_page, got_count;
    logic [15:0] uart_divisor;
    logic [31:0] got_word;
    int failures = 0, checks = 0, quiet_low = 0;
    bml_row_type rows [16] = '{
        '{4'h0, ST_IDLE, 1'b0, 32'h0}, '{4'h1, ST_LOAD, 1'b1, 32'h2000_0000},
        '{4'h2, ST_LOAD, 1'b1, 32'h2030_0000}, '{4'h3, ST_LOAD, 1'b0, 32'h0},
        '{4'h4, ST_LOAD, 1'b0, 32'h0}, '{4'h5, ST_LOAD, 1'b1, 32'h0},
        '{4'h6, ST_LOAD, 1'b0, 32'h0}, '{4'h7, ST_AUTOBAUD, 1'b0, 32'h0},
        '{4'h8, ST_AUTOBAUD, 1'b0, 32'h0}, '{4'h9, ST_IDLE, 1'b0, 32'h0},
        '{4'hA, ST_LOAD, 1'b1, 32'h0000_0010}, '{4'hB, ST_LOAD, 1'b0, 32'h0},
        '{4'hC, ST_LOAD, 1'b1, 32'h0}, '{4'hD, ST_LOAD, 1'b1, 32'h0},
        '{4'hE, ST_LOAD, 1'b0, 32'h0}, '{4'hF, ST_LOAD, 1'b0, 32'h0}};

    always #2 sys_clk = ~sys_clk;

    // Host line reaches only the port of the mode; the other receive idles high
    assign uart_zero_receive = port_one ? 1'b1 : host_tx;
    assign uart_one_receive = port_one ? host_tx : 1'b1;
    assign host_rx = port_one ? uart_one_transmit : uart_zero_transmit;

    // Any activity on the unused transmit pin is counted as a fault
    always @(posedge sys_clk) begin
        if ((port_one ? uart_zero_transmit : uart_one_transmit) !== 1'b1) quiet_low++;
    end

    bml_loader #(.DIV_W(16)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sw_reset(sw_reset),
        .boot_select_pins(boot_select_pins), .otp_async_ready_input_enable(otp_async_ready_input_enable),
        .otp_twowire_one_byte(otp_twowire_one_byte), .otp_page_override(otp_page_override),
        .otp_start_page(otp_start_page), .load_step(load_step), .spi_detected(spi_detected),
        .loader_busy(loader_busy), .uart_zero_receive(uart_zero_receive),
        .uart_one_receive(uart_one_receive), .boot_mode(boot_mode),
        .loader_state(loader_state), .boot_cfg(boot_cfg), .host_wait(host_wait),
        .dma_request_one_n(dma_request_one_n),
        .spi_memory_select_gpio_n(spi_memory_select_gpio_n), .spi_addr_bytes(spi_addr_bytes),
        .otp_page(otp_page), .uart_zero_transmit(uart_zero_transmit),
        .uart_one_transmit(uart_one_transmit), .uart_divisor(uart_divisor));

    bml_uart_host #(.BIT_CYC(64)) host (
        .sys_clk(sys_clk), .host_wait(host_wait), .host_rx(host_rx), .host_tx(host_tx),
        .got_word(got_word), .got_count(got_count));

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // Pins settle well before the software reset so the sample is clean
    task automatic boot(input logic [3:0] m);
        tick(1);
        boot_select_pins <= m;
        tick(3);
        sw_reset <= 1'b1;
        tick(1);
        sw_reset <= 1'b0;
        tick(10);
        @(negedge sys_clk);
    endtask : boot

    task automatic steps(input int n);
        tick(1);
        load_step <= 1'b1;
        tick(n);
        load_step <= 1'b0;
    endtask : steps

    // Autobaud at 64 cycles a bit gives divisor 4 and a 64-cycle reply bit
    task automatic uart_run(input logic p);
        int start;
        int guard;
        port_one <= p;
        boot(p ? 4'h8 : 4'h7);
        quiet_low = 0;
        start = got_count;
        guard = 0;
        host.send_byte(8'h40, 1'b0);
        while (got_count != 8'(start + 4) && guard < 5000) begin
            tick(1);
            guard++;
        end
        if (guard >= 5000) begin
            failures++;
            give_verdict();
        end
        tick(70);
        @(negedge sys_clk);
        check("divisor", uart_divisor, 16'h0004);
        check("ack", got_word, 32'h0000_04BF);
        check("quiet", quiet_low, 0);
        check("state", loader_state, ST_LOAD);
        host.send_byte(8'hA5, 1'b1);
    endtask : uart_run

    initial begin
        tick(5);
        rst_n <= 1'b1;
        tick(10);
        @(negedge sys_clk);
        check("mode", boot_mode, 4'h0);
        check("state", loader_state, ST_IDLE);
        foreach (rows[i]) begin
            boot(rows[i].mode);
            check("mode", boot_mode, rows[i].mode);
            check("state", loader_state, rows[i].st);
            if (rows[i].chk) check("addr", boot_cfg.start_addr, rows[i].addr);
            case (rows[i].mode)
                4'h1: begin
                    check("timing", {boot_cfg.async_hold, boot_cfg.async_access, boot_cfg.async_setup}, 12'h3F4);
                    check("async_ready_input", {boot_cfg.async_ready_input_en, boot_cfg.async_pins_en}, 2'b01);
                end
                4'h3: begin
                    check("baud", boot_cfg.spi_baud, 16'h0085);
                    check("gpio", spi_memory_select_gpio_n, 1'b0);
                end
                4'h5: begin
                    check("twclk", {boot_cfg.tw_twowire_prescaler, boot_cfg.tw_clkdiv}, 24'h0A_0811);
                    check("twid", {boot_cfg.tw_dev_id, boot_cfg.tw_addr_bytes}, {8'hA0, 3'h2});
                end
                4'h6: check("twid", boot_cfg.tw_dev_id, 8'h5F);
                4'hB: check("page", otp_page, 8'h40);
                4'hC, 4'hD: check("nand", {boot_cfg.nand_ctl, boot_cfg.nand_data_on_port_h, boot_cfg.nand_addr_cycles}, {16'h0033, rows[i].mode[0], 3'h4});
                4'h0, 4'h9: check("wait", host_wait, 1'b1);
                default: ;
            endcase
        end
        // Power-on reset resamples; later pin moves are ignored
        tick(1);
        boot_select_pins <= 4'h5;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(8);
        boot_select_pins <= 4'hC;
        tick(20);
        @(negedge sys_clk);
        check("mode", boot_mode, 4'h5);
        check("twid", boot_cfg.tw_dev_id, 8'hA0);
        // Programmed settings override the defaults
        tick(1);
        otp_async_ready_input_enable <= 1'b1;
        otp_twowire_one_byte <= 1'b1;
        otp_page_override <= 1'b1;
        otp_start_page <= 8'h20;
        boot(4'h1);
        check("async_ready_input", boot_cfg.async_ready_input_en, 1'b1);
        boot(4'h5);
        check("twbytes", boot_cfg.tw_addr_bytes, 3'h1);
        boot(4'hB);
        check("page", otp_page, 8'h20);
        steps(1);
        @(negedge sys_clk);
        check("page", otp_page, 8'h21);
        steps(200);
        @(negedge sys_clk);
        check("page", otp_page, 8'hDF);
        otp_async_ready_input_enable <= 1'b0;
        otp_twowire_one_byte <= 1'b0;
        otp_page_override <= 1'b0;
        // One request pulse per word, single and back to back
        boot(4'h2);
        for (int n = 1; n < 3; n++) begin
            steps(n);
            @(negedge sys_clk);
            check("dreq", dma_request_one_n, 1'b0);
            @(negedge sys_clk);
            check("dreq", dma_request_one_n, 1'b1);
        end
        // Address bytes stop at four, or at detection
        boot(4'h3);
        steps(6);
        @(negedge sys_clk);
        check("abytes", spi_addr_bytes, 3'h4);
        boot(4'h3);
        steps(2);
        spi_detected <= 1'b1;
        steps(3);
        @(negedge sys_clk);
        check("abytes", spi_addr_bytes, 3'h2);
        spi_detected <= 1'b0;
        // Host wait follows the busy datapath one cycle later
        boot(4'h1);
        check("wait", host_wait, 1'b0);
        tick(1);
        loader_busy <= 1'b1;
        @(negedge sys_clk);
        check("wait", host_wait, 1'b0);
        @(negedge sys_clk);
        check("wait", host_wait, 1'b1);
        tick(1);
        loader_busy <= 1'b0;
        uart_run(1'b0);
        uart_run(1'b1);
        give_verdict();
    end
endmodule : tb_bml_loader
`default_nettype wire
